// File: src/sac_pkg.sv
/*
  shared constants, state codes and helpers of the conversion sequencer.
  assumes a 10 MHz system clock and a 16-bit converter core.
*/
package sac_pkg;
  // converter width and clock rate
  localparam int RES_W = 16;
  localparam int CLK_PERIOD_NS = 100;
  // least acquisition time, rounded up to whole cycles
  localparam int ACQ_MIN_NS = 1100;
  localparam int ACQ_MIN_CYC = (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] ACQ_MIN_CNT = 8'(ACQ_MIN_CYC);
  // longest conversion time, rounded down; one decision per step
  localparam int CONV_MAX_NS = 4700;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int CONV_STEP_CYC = (CONV_MAX_CYC - 4) / RES_W;
  localparam logic [3:0] STEP_LAST = 4'(CONV_STEP_CYC - 1);
  localparam logic [3:0] MSB_IDX = 4'(RES_W - 1);
  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  // reset values
  localparam logic ENABLE_RESET = 1'b1;
  localparam logic SHUTDOWN_RESET = 1'b1;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  // interrupt layout: done, ignored strobe, short acquisition
  localparam int IRQ_N = 3;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SAC_IDLE = 3'h0,
    SAC_ACQ = 3'h1,
    SAC_CONV = 3'h2,
    SAC_DONE = 3'h3,
    SAC_READ = 3'h4
  } sac_state_t;

  // word placed on the data lines for the chosen width and byte
  function automatic logic [15:0] sac_present(input logic [15:0] r, input logic byte_wide,
                                               input logic upper);
    sac_present = byte_wide ? {8'h00, (upper ? r[15:8] : r[7:0])} : r;
  endfunction

  function automatic logic sac_mapped(input logic [7:0] a);
    sac_mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_RESULT) ||
                 (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK);
  endfunction
endpackage

// File: src/sac_sar_if.sv
/*
  link between the sequencer and its approximation engine.
  assumes both ends share clock_i.
*/
`timescale 1ns/10ps
interface sac_sar_if;
  logic start;
  logic compare;
  logic busy;
  logic done;
  logic [15:0] result;
  logic [15:0] dac_code;

  modport seq (output start, output compare, input busy, input done, input result, input dac_code);
  modport eng (input start, input compare, output busy, output done, output result, output dac_code);
endinterface

// File: src/sac_sar_engine.sv
/*
  successive-approximation engine with its own step timer.
  assumes compare is high while the held input is at or above dac_code.
*/
`timescale 1ns/10ps
module sac_sar_engine (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // sequencer side
  sac_sar_if.eng sar
);
  logic busy_reg;
  logic done_reg;
  logic [15:0] code_reg;
  logic [15:0] result_reg;
  logic [3:0] idx_reg;
  logic [3:0] div_reg;

  // step timer made here, the controller gives no conversion clock
  wire tick = busy_reg && (div_reg == sac_pkg::STEP_LAST);
  wire [15:0] trial = 16'h0001 << idx_reg;
  wire [15:0] kept = sar.compare ? code_reg : (code_reg & ~trial);
  wire last = (idx_reg == 4'h0);

  assign sar.busy = busy_reg;
  assign sar.done = done_reg;
  assign sar.result = result_reg;
  assign sar.dac_code = code_reg;

  // one decision per tick, msb first; a start while busy is dropped
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      code_reg <= 16'h0000;
      result_reg <= 16'h0000;
      idx_reg <= 4'h0;
      div_reg <= 4'h0;
    end else begin
      done_reg <= 1'b0;
      if (sar.start && !busy_reg) begin
        busy_reg <= 1'b1;
        code_reg <= 16'h8000;
        idx_reg <= sac_pkg::MSB_IDX;
        div_reg <= 4'h0;
      end else if (busy_reg) begin
        div_reg <= tick ? 4'h0 : div_reg + 4'h1;
        if (tick) begin
          code_reg <= last ? kept : (kept | (trial >> 1));
          idx_reg <= idx_reg - 4'h1;
          busy_reg <= !last;
          done_reg <= last;
          result_reg <= last ? kept : result_reg;
        end
      end
    end
  end
endmodule

// File: src/sac_irq_bank.sv
/*
  sticky interrupt flags, write-one-to-clear, with a mask and one level output.
  assumes set and clear pulses are synchronous to clock_i.
*/
`timescale 1ns/10ps
module sac_irq_bank #(
  parameter int N = 3
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // events and software access
  input wire logic [N-1:0] set_i,
  input wire logic [N-1:0] clr_i,
  input wire logic mask_we_i,
  input wire logic [N-1:0] mask_i,
  // state
  output logic [N-1:0] status_o,
  output logic [N-1:0] mask_o,
  output logic irq_o
);
  logic [N-1:0] status_reg;
  logic [N-1:0] mask_reg;

  // a set in the clearing cycle wins, so no event is lost
  wire [N-1:0] status_next = (status_reg & ~clr_i) | set_i;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_reg <= '0;
      mask_reg <= N'(sac_pkg::IRQ_MASK_RESET);
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_we_i ? mask_i : mask_reg;
    end
  end

  assign status_o = status_reg;
  assign mask_o = mask_reg;
  assign irq_o = |(status_reg & mask_reg);
endmodule

// File: src/sac_sequencer.sv
/*
  conversion sequencer of a 16-bit successive-approximation converter:
  strobe decoding, power-down choice, three-state result port, register file on AXI4-Lite.
  assumes strobe pins synchronous to clock_i and an analog core driven by track/dac/ref outputs.
*/
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module sac_sequencer #(
  parameter bit BYTE_WIDE = 1'b0
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // controller pins
  input wire logic cs_b_i,
  input wire logic read_conv_i,
  input wire logic upper_byte_select_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  output logic done_b_o,
  // analog core
  output logic track_o,
  output logic ref_on_o,
  output logic [15:0] dac_code_o,
  input wire logic compare_i,
  // interrupt
  output logic irq_o
);
  sac_pkg::sac_state_t state_reg, state_next;
  logic cs_q_reg;
  logic enable_reg;
  logic pd_shutdown_reg;
  logic ref_on_reg;
  logic track_reg;
  logic done_b_reg;
  logic [15:0] result_reg;
  logic [7:0] acq_cnt_reg;
  logic data_oe_reg;
  logic [15:0] data_out_reg;
  logic aw_held_reg;
  logic [7:0] awaddr_reg;
  logic w_held_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;

  sac_sar_if sar ();

  sac_sar_engine u_engine (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .sar(sar)
  );

  // strobe edge decode; pins are already in the clock domain
  wire cs_fall = cs_q_reg && !cs_b_i;
  wire strobe_fall = cs_fall && enable_reg;
  wire in_idle = (state_reg == sac_pkg::SAC_IDLE);
  wire in_acq = (state_reg == sac_pkg::SAC_ACQ);
  wire in_conv = (state_reg == sac_pkg::SAC_CONV);
  wire in_done = (state_reg == sac_pkg::SAC_DONE);
  wire acq_start = strobe_fall && !read_conv_i && (in_idle || in_done);
  wire conv_start = strobe_fall && in_acq;
  wire read_start = strobe_fall && read_conv_i && in_done;
  wire ignored_fall = cs_fall && in_conv;
  wire short_acq = conv_start && (acq_cnt_reg < sac_pkg::ACQ_MIN_CNT);
  wire conv_end = sar.done && in_conv;

  assign sar.start = conv_start;
  assign sar.compare = compare_i;

  // sequence; the convert state waits only for the engine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sac_pkg::SAC_IDLE: begin
        if (acq_start) begin
          state_next = sac_pkg::SAC_ACQ;
        end
      end
      sac_pkg::SAC_ACQ: begin
        if (conv_start) begin
          state_next = sac_pkg::SAC_CONV;
        end
      end
      sac_pkg::SAC_CONV: begin
        if (conv_end) begin
          state_next = sac_pkg::SAC_DONE;
        end
      end
      sac_pkg::SAC_DONE: begin
        if (read_start) begin
          state_next = sac_pkg::SAC_READ;
        end else if (acq_start) begin
          state_next = sac_pkg::SAC_ACQ;
        end
      end
      sac_pkg::SAC_READ: begin
        if (cs_b_i) begin
          state_next = sac_pkg::SAC_IDLE;
        end
      end
      default: begin
        state_next = sac_pkg::SAC_IDLE;
      end
    endcase
  end

  // state and strobe history
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= sac_pkg::SAC_IDLE;
      cs_q_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cs_q_reg <= cs_b_i;
    end
  end

  // power mode is sampled at the hold edge and applied when conversion ends
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pd_shutdown_reg <= sac_pkg::SHUTDOWN_RESET;
      ref_on_reg <= 1'b0;
      track_reg <= 1'b0;
    end else begin
      pd_shutdown_reg <= conv_start ? read_conv_i : pd_shutdown_reg;
      ref_on_reg <= acq_start | (conv_end ? !pd_shutdown_reg : ref_on_reg);
      track_reg <= acq_start | (track_reg & !conv_start);
    end
  end

  // done flag and result; flag returns high at the next acquisition
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_b_reg <= 1'b1;
      result_reg <= 16'h0000;
    end else begin
      done_b_reg <= conv_end ? 1'b0 : (acq_start | done_b_reg);
      result_reg <= conv_end ? sar.result : result_reg;
    end
  end

  // acquisition length, saturating at the least legal count
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acq_cnt_reg <= 8'h00;
    end else if (acq_start) begin
      acq_cnt_reg <= 8'h00;
    end else if (in_acq && acq_cnt_reg < sac_pkg::ACQ_MIN_CNT) begin
      acq_cnt_reg <= acq_cnt_reg + 8'h01;
    end
  end

  // result port from flip-flops; released the cycle after the strobe rises
  wire [15:0] present = sac_pkg::sac_present(result_reg, BYTE_WIDE, upper_byte_select_i);
  wire presenting = (state_next == sac_pkg::SAC_READ);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_oe_reg <= 1'b0;
      data_out_reg <= 16'h0000;
    end else begin
      data_oe_reg <= presenting;
      data_out_reg <= presenting ? present : 16'h0000;
    end
  end

  assign data_o = data_out_reg;
  assign data_oe_o = data_oe_reg;
  assign done_b_o = done_b_reg;
  assign track_o = track_reg;
  assign ref_on_o = ref_on_reg;
  assign dac_code_o = sar.dac_code;

  // bus channels; address and data are held until both are in
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_lane0 = wr_fire && wstrb0_reg;
  wire wr_ctrl = wr_lane0 && (awaddr_reg == sac_pkg::ADDR_CTRL);
  wire wr_irq_stat = wr_lane0 && (awaddr_reg == sac_pkg::ADDR_IRQ_STAT);
  wire wr_irq_mask = wr_lane0 && (awaddr_reg == sac_pkg::ADDR_IRQ_MASK);
  wire rd_fire = s_axi_arvalid && !rvalid_reg;
  wire [31:0] status_word = {25'h0000000, done_b_reg, sar.busy, ref_on_reg, pd_shutdown_reg,
                             state_reg};
  wire [31:0] rd_word =
    (s_axi_araddr == sac_pkg::ADDR_CTRL) ? {31'h00000000, enable_reg} :
    (s_axi_araddr == sac_pkg::ADDR_STATUS) ? status_word :
    (s_axi_araddr == sac_pkg::ADDR_RESULT) ? {16'h0000, result_reg} :
    (s_axi_araddr == sac_pkg::ADDR_IRQ_STAT) ? {29'h00000000, irq_status} :
    (s_axi_araddr == sac_pkg::ADDR_IRQ_MASK) ? {29'h00000000, irq_mask} : 32'h00000000;

  // write side
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb0_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response; unmapped words answer slverr
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= sac_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= sac_pkg::sac_mapped(awaddr_reg) ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read side, answered the cycle after the address is taken
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= sac_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= sac_pkg::sac_mapped(s_axi_araddr) ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // enable gates the strobe falls; disabled, no fall moves the sequence, and a rise still ends a read
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      enable_reg <= sac_pkg::ENABLE_RESET;
    end else if (wr_ctrl) begin
      enable_reg <= wdata_reg[0];
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // events: conversion done, ignored strobe, short acquisition
  sac_irq_bank #(
    .N(sac_pkg::IRQ_N)
  ) u_irq (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .set_i({short_acq, ignored_fall, conv_end}),
    .clr_i(wr_irq_stat ? wdata_reg[2:0] : 3'h0),
    .mask_we_i(wr_irq_mask),
    .mask_i(wdata_reg[2:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // checks
  localparam int CONV_BOUND = sac_pkg::CONV_MAX_CYC;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  AST_DONE_IN_TIME: assert property (conv_start |-> ##[1:CONV_BOUND] !done_b_o)
    else $error("done flag late after hold edge");
  AST_HOLD_AT_EDGE: assert property (conv_start |=> !track_o && sar.busy)
    else $error("hold or conversion did not start");
  AST_MODE_CAPTURE: assert property (conv_start |=> pd_shutdown_reg == $past(read_conv_i))
    else $error("power mode not captured");
  AST_MODE_ENTER: assert property ($fell(done_b_o) |-> ref_on_o == !pd_shutdown_reg)
    else $error("wrong power mode after conversion");
  AST_ACQ_ENTRY: assert property (in_idle && strobe_fall && !read_conv_i |=> in_acq && track_o)
    else $error("acquisition not entered");
  AST_RELEASED: assert property (data_oe_o |-> $past(!cs_b_i))
    else $error("data driven without strobe");
  AST_READ_DRIVE: assert property (read_start |=> data_oe_o && !done_b_o)
    else $error("result not presented");
  AST_BYTE_VIEW: assert property (data_oe_o |->
      data_o == sac_pkg::sac_present(result_reg, BYTE_WIDE, $past(upper_byte_select_i)))
    else $error("wrong data on the result port");
  AST_IGNORE_CONV: assert property (in_conv && cs_fall && !sar.done |=> in_conv)
    else $error("strobe disturbed conversion");
  AST_DONE_LOW: assert property (conv_end |=> !done_b_o ##1 !done_b_o)
    else $error("done flag not lowered");

  CV_FULL_CYCLE: cover property (conv_start ##[1:CONV_BOUND] read_start);
  CV_SHUTDOWN: cover property (conv_end && pd_shutdown_reg);
  CV_IGNORED: cover property (ignored_fall);
  CV_IRQ: cover property ($rose(irq_o));
endmodule

// File: tb/sac_ctl_model.sv
/*
  controller-side model: strobe and select pins plus a held-sample comparator.
  assumes its tasks are called just after a rising clock_i edge.
*/
`timescale 1ns/10ps
module sac_ctl_model (
  // clock
  input wire logic clock_i,
  // analog side
  input wire logic [15:0] analog_in_i,
  input wire logic track_i,
  input wire logic [15:0] dac_code_i,
  output logic compare_o,
  // strobe pins
  output logic cs_b_o,
  output logic read_conv_o,
  output logic upper_byte_select_o
);
  logic [15:0] held_reg;

  // sample follows the source only while the switch is closed
  always_ff @(posedge clock_i) begin
    if (track_i) begin
      held_reg <= analog_in_i;
    end
  end
  assign compare_o = (held_reg >= dac_code_i);

  // pins idle with the strobe high
  initial begin
    cs_b_o = 1'b1;
    read_conv_o = 1'b0;
    upper_byte_select_o = 1'b0;
  end

  // select set together with the strobe, so it is steady at the edge
  task automatic fall(input logic rc);
    @(posedge clock_i);
    cs_b_o <= 1'b0;
    read_conv_o <= rc;
    upper_byte_select_o <= ~upper_byte_select_o;
  endtask

  // strobe back high, ends a read
  task automatic rise();
    @(posedge clock_i);
    cs_b_o <= 1'b1;
  endtask
endmodule

// File: tb/tb.sv
/*
  self-checking bench of the conversion sequencer: bus, strobe sequences, interrupts.
  assumes the controller model sac_ctl_model and a 10 MHz clock.
*/
`timescale 1ns/10ps
module tb;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic cs_b_i, read_conv_i, upper_byte_select_i, data_oe_o, done_b_o, track_o, ref_on_o, compare_i, irq_o;
  logic [15:0] data_o, dac_code_o, analog_in, v, e, data_b;
  logic mode, data_oe_b;
  logic [3:0] strb = 4'hF;
  int err_total = 0;
  int checked = 0;
  int seed = 8;
  int cyc = 0;
  int n;

  always #50 clock_i = ~clock_i;

  sac_sequencer #(.BYTE_WIDE(1'b0)) i_dut (
    .clock_i, .rst_b_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cs_b_i, .read_conv_i, .upper_byte_select_i, .data_o, .data_oe_o, .done_b_o, .track_o,
    .ref_on_o, .dac_code_o, .compare_i, .irq_o
  );

  // byte-wide build on the same pins, so both widths see every sequence; bus outputs left open
  sac_sequencer #(.BYTE_WIDE(1'b1)) i_dut_byte (
    .clock_i, .rst_b_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready,
    .cs_b_i, .read_conv_i, .upper_byte_select_i, .data_o(data_b), .data_oe_o(data_oe_b), .done_b_o(),
    .track_o(), .ref_on_o(), .dac_code_o(), .compare_i, .irq_o()
  );

  sac_ctl_model i_ctl (
    .clock_i, .analog_in_i(analog_in), .track_i(track_o), .dac_code_i(dac_code_o),
    .compare_o(compare_i), .cs_b_o(cs_b_i), .read_conv_o(read_conv_i),
    .upper_byte_select_o(upper_byte_select_i)
  );

  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // binary search against an ideal comparator
  function automatic logic [15:0] sar_expect(input logic [15:0] a);
    logic [15:0] code;
    code = 16'h0000;
    for (int b = 15; b >= 0; b--) begin
      if (a >= (code | (16'h0001 << b))) begin
        code = code | (16'h0001 << b);
      end
    end
    return code;
  endfunction

  // write: both channels offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic a_ok, w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge clock_i);
      if (s_axi_awready === 1'b1 && !a_ok) begin
        a_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock_i); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // read: hangs are cut by the cycle ceiling
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock_i); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // cycle ceiling, far above the five hundred or so that the run needs
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    analog_in = 16'h0000;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    // reset values, unmapped place on both channels
    axi_rd(sac_pkg::ADDR_CTRL);
    chk("ctrl", rd[0], 1'b1);
    axi_rd(sac_pkg::ADDR_STATUS);
    chk("status", rd[3:0], 4'h8);
    axi_rd(sac_pkg::ADDR_IRQ_MASK);
    chk("mask", rd[2:0], 3'h0);
    axi_rd(8'h14);
    chk("unmapped read resp", rs, sac_pkg::RESP_SLVERR);
    chk("unmapped read", rd, 32'h0);
    axi_wr(8'h14, 32'hFFFFFFFF);
    chk("unmapped write", rs, sac_pkg::RESP_SLVERR);
    // lane 0 strobe off: answered, but the enable keeps its value
    strb = 4'hE;
    axi_wr(sac_pkg::ADDR_CTRL, 32'h0);
    strb = 4'hF;
    chk("lane0 off resp", rs, sac_pkg::RESP_OKAY);
    axi_rd(sac_pkg::ADDR_CTRL);
    chk("lane0 off", rd[0], 1'b1);
    // disabled strobe, then idle fall with select high: both ignored
    axi_wr(sac_pkg::ADDR_CTRL, 32'h0);
    i_ctl.fall(1'b0);
    i_ctl.rise();
    repeat (2) @(posedge clock_i);
    chk("disabled", track_o, 1'b0);
    axi_wr(sac_pkg::ADDR_CTRL, 32'h1);
    i_ctl.fall(1'b1);
    i_ctl.rise();
    repeat (2) @(posedge clock_i);
    chk("idle read select", {track_o, data_oe_o}, 2'h0);
    axi_wr(sac_pkg::ADDR_IRQ_MASK, 32'h7);
    // random samples with full-scale and zero among them
    for (int i = 0; i < 8; i++) begin
      v = 16'($random(seed));
      mode = 1'($random(seed));
      if (i == 1) v = 16'hFFFF;
      if (i == 2) v = 16'h0000;
      analog_in <= v;
      i_ctl.fall(1'b0);
      i_ctl.rise();
      @(posedge clock_i);
      chk("acquire", {track_o, ref_on_o, done_b_o}, 3'h7);
      // last pass holds too early on purpose
      repeat ((i == 7) ? 3 : 12) @(posedge clock_i);
      i_ctl.fall(mode);
      i_ctl.rise();
      n = 0;
      if (i == 0) begin
        repeat (5) @(posedge clock_i);
        i_ctl.fall(1'b1);
        i_ctl.rise();
        n = 7;
      end
      do begin
        @(posedge clock_i);
        n++;
        chk("hold", {track_o, data_oe_o}, 2'h0);
      end while (done_b_o !== 1'b0 && n < 100);
      chk("conversion time", n <= 48, 1'b1);
      @(posedge clock_i);
      chk("power mode", ref_on_o, !mode);
      i_ctl.fall(1'b1);
      repeat (2) @(posedge clock_i);
      e = sar_expect(v);
      chk("result", data_o, e);
      chk("result byte", data_b, {8'h00, (upper_byte_select_i ? e[15:8] : e[7:0])});
      chk("data on", {data_oe_o, data_oe_b}, 2'h3);
      i_ctl.rise();
      repeat (2) @(posedge clock_i);
      chk("data off", {data_oe_o, data_o}, 17'h0);
      chk("byte data off", {data_oe_b, data_b}, 17'h0);
      if (i == 0) begin
        axi_rd(sac_pkg::ADDR_IRQ_STAT);
        chk("irq done and ignored", {irq_o, rd[2:0]}, 4'hB);
        axi_wr(sac_pkg::ADDR_IRQ_STAT, 32'h3);
        axi_rd(sac_pkg::ADDR_IRQ_STAT);
        chk("irq cleared", {irq_o, rd[2:0]}, 4'h0);
        axi_wr(sac_pkg::ADDR_IRQ_MASK, 32'h0);
      end
    end
    // short acquisition flagged, masked line stays low until unmasked
    axi_rd(sac_pkg::ADDR_IRQ_STAT);
    chk("irq short acquisition", {irq_o, rd[2:0]}, 4'h5);
    axi_wr(sac_pkg::ADDR_IRQ_MASK, 32'h4);
    chk("irq unmasked", irq_o, 1'b1);
    // reset in mid-run clears flags, line and pins
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk("in reset", {irq_o, data_oe_o, done_b_o, track_o}, 4'h2);
    rst_b_i <= 1'b1;
    axi_rd(sac_pkg::ADDR_IRQ_STAT);
    chk("irq after reset", {irq_o, rd[2:0]}, 4'h0);
    report_and_stop();
  end
endmodule
